// *** logic/nbcs_sequencer.sv ***
`timescale 1ns/1ns
`default_nettype none
module nbcs_sequencer #(
  parameter int unsigned MS_CYCLES_P      = nbcs_pkg::MS_CYCLES,
  parameter int unsigned MEAS_CYCLES_P    = nbcs_pkg::MEAS_CYCLES,
  parameter int unsigned GATE_ON_CYCLES_P = nbcs_pkg::GATE_ON_CYCLES,
  parameter int unsigned TOPOFF_OFF_P     = nbcs_pkg::TOPOFF_OFF_CYCLES,
  parameter int unsigned TRICKLE_SCALE_P  = nbcs_pkg::CLK_HZ,
  parameter int unsigned SAMPLE_MS_P      = nbcs_pkg::SAMPLE_MS,
  parameter int unsigned MS_PER_MIN_P     = nbcs_pkg::MS_PER_MIN
) (
  input  wire logic        SYS_CLK_IN,
  input  wire logic        RST_IN,
  input  wire logic        HSEL_IN,
  input  wire logic [31:0] HADDR_IN,
  input  wire logic [1:0]  HTRANS_IN,
  input  wire logic        HWRITE_IN,
  input  wire logic [2:0]  HSIZE_IN,
  input  wire logic [31:0] HWDATA_IN,
  input  wire logic        HREADY_IN,
  output logic      [31:0] HRDATA_OUT,
  output logic             HREADYOUT_OUT,
  output logic             HRESP_OUT,
  input  wire logic        SUPPLY_OK_IN,
  input  wire logic        DISCHARGE_REQUEST_N_IN,
  input  wire logic        CHARGE_HOLD_N_IN,
  input  wire logic        CELL_OVER_MAX_IN,
  input  wire logic        CELL_UNDER_EDV_IN,
  input  wire logic        TEMP_UNDER_TCO_IN,
  input  wire logic        TEMP_OVER_LTF_IN,
  input  wire logic        TEMP_UNDER_HTF_IN,
  input  wire logic        TEMP_OVER_TCO_WIN_IN,
  input  wire logic [11:0] BATTERY_PAIR_VOLTAGE_CODE_IN,
  input  wire logic [11:0] THERMAL_VOLTAGE_CODE_IN,
  output logic             CHARGE_GATE_OUT,
  output logic             CHARGE_GATE_OE_OUT,
  output logic             DISCHARGE_DRIVE_OUT,
  output logic             DISCHARGE_DRIVE_OE_OUT,
  output logic             LAMP_BLANK_OUT
);
  function automatic logic [1:0] level_of(input logic [1:0] x);
    level_of = (x == 2'h3) ? nbcs_pkg::LEVEL_HIGH : x;
  endfunction

  nbcs_pkg::nbcs_state_t state_q, state_d;
  logic [5:0]  cfg_q;
  logic        prev_supply_q, prev_hold_n_q, prev_dreq_n_q, prev_over_q;
  logic [31:0] ms_div_q, state_ms_q, samp_ms_q, pulse_q, meas_div_q;
  logic        burst_q, done_q, gate_q, gate_d, holdoff_q;
  logic [5:0]  meas_idx_q;
  logic [16:0] vsum_q;
  logic [15:0] tsum_q;
  logic [11:0] vsamp_q, tsamp_q, vmax_q, t1_q, t2_q;
  logic        vmax_ok_q;
  logic [1:0]  tcount_q;
  logic [2:0]  cause_q;
  logic [31:0] hrdata_q;
  logic        hwr_q;
  logic [7:0]  haddr_q;
  logic        gate_oe_q, dis_q, dis_oe_q, blank_q;

  logic [1:0]  voltage_term_select;
  logic        peak_mode, drop_mode, topoff_en, ms_tick, meas_tick;
  logic [3:0]  cfg_idx;
  logic [31:0] safety_ms, holdoff_ms, trk_period;
  logic        supply_rise, hold_rise, over_fall, dreq_fall, new_cycle;
  logic        temp_bad, max_temp, time_up, volt_hit, slope_hit, entry;
  logic        v_win, t_win;
  logic [11:0] vs_now, ts_now;
  logic [31:0] trk_per [nbcs_pkg::CFG_COMBOS];

  assign voltage_term_select      = level_of(cfg_q[nbcs_pkg::CFG_VOLTAGE_TERM_SELECT_LSB +: 2]);
  assign peak_mode = (voltage_term_select == nbcs_pkg::LEVEL_HIGH);
  assign drop_mode = (voltage_term_select == nbcs_pkg::LEVEL_FLOAT);
  assign cfg_idx   = 4'(3 * level_of(cfg_q[nbcs_pkg::CFG_TMB_LSB +: 2])
                     + level_of(cfg_q[nbcs_pkg::CFG_TMA_LSB +: 2]));
  assign safety_ms  = nbcs_pkg::SAFETY_MIN[cfg_idx] * MS_PER_MIN_P;
  assign holdoff_ms = nbcs_pkg::HOLDOFF_S[cfg_idx] * nbcs_pkg::MS_PER_S;
  assign topoff_en  = nbcs_pkg::TOPOFF_EN_MAP[cfg_idx];

  // Trickle periods are fixed divisions, built once per setting.
  genvar gi;
  generate
    for (gi = 0; gi < nbcs_pkg::CFG_COMBOS; gi++)
    begin : g_trk
      if (nbcs_pkg::TRICKLE_HZ[gi] == 0)
      begin : g_off
        assign trk_per[gi] = 32'h0;
      end
      else
      begin : g_on
        assign trk_per[gi] = TRICKLE_SCALE_P / nbcs_pkg::TRICKLE_HZ[gi];
      end
    end
  endgenerate
  assign trk_period = trk_per[cfg_idx];

  assign supply_rise = SUPPLY_OK_IN && !prev_supply_q;
  assign hold_rise   = CHARGE_HOLD_N_IN && !prev_hold_n_q;
  assign over_fall   = prev_over_q && !CELL_OVER_MAX_IN &&
                       (state_q != nbcs_pkg::ST_MCV_CHECK);
  assign new_cycle   = supply_rise || hold_rise || over_fall;
  assign dreq_fall   = prev_dreq_n_q && !DISCHARGE_REQUEST_N_IN;
  assign temp_bad    = TEMP_UNDER_HTF_IN ||
                       (!peak_mode && TEMP_OVER_LTF_IN);
  assign max_temp    = TEMP_UNDER_TCO_IN ||
                       (!peak_mode && TEMP_OVER_LTF_IN);
  assign time_up     = (state_ms_q >= safety_ms);
  assign ms_tick     = (ms_div_q == MS_CYCLES_P - 1);
  assign meas_tick   = burst_q && (meas_div_q == MEAS_CYCLES_P - 1);

  assign vs_now = peak_mode ? vsum_q[16:5] : vsum_q[15:4];
  assign ts_now = tsum_q[15:4];
  assign v_win  = !CELL_UNDER_EDV_IN && !CELL_OVER_MAX_IN;
  assign t_win  = !TEMP_UNDER_TCO_IN &&
                  (peak_mode ? !TEMP_OVER_TCO_WIN_IN
                             : !TEMP_OVER_LTF_IN);
  assign volt_hit = done_q && v_win && vmax_ok_q && !holdoff_q &&
                    ((peak_mode && {1'b0, vmax_q} >=
                      {1'b0, vs_now} + nbcs_pkg::DROP_PK_CODES) ||
                     (drop_mode && {1'b0, vmax_q} >=
                      {1'b0, vs_now} + nbcs_pkg::DROP_VD_CODES));
  assign slope_hit = done_q && t_win && (tcount_q == 2'h2) &&
                     ({1'b0, t2_q} >= {1'b0, ts_now} +
                      nbcs_pkg::TEMP_FALL_CODES);

  always_comb
  begin
    state_d = state_q;
    if (!CHARGE_HOLD_N_IN)
      state_d = nbcs_pkg::ST_HOLD;
    else if (dreq_fall)
      state_d = nbcs_pkg::ST_DISCHARGE;
    else if (new_cycle)
      state_d = DISCHARGE_REQUEST_N_IN ? nbcs_pkg::ST_QUALIFY
                                       : nbcs_pkg::ST_DISCHARGE;
    else
      case (state_q)
        nbcs_pkg::ST_DISCHARGE:
          if (CELL_UNDER_EDV_IN)
            state_d = nbcs_pkg::ST_QUALIFY;
        nbcs_pkg::ST_QUALIFY, nbcs_pkg::ST_PENDING:
          if (CELL_OVER_MAX_IN)
            state_d = nbcs_pkg::ST_ABSENT;
          else if (temp_bad || CELL_UNDER_EDV_IN)
            state_d = nbcs_pkg::ST_PENDING;
          else
            state_d = nbcs_pkg::ST_FAST;
        nbcs_pkg::ST_FAST:
          if (CELL_OVER_MAX_IN)
            state_d = nbcs_pkg::ST_MCV_CHECK;
          else if (max_temp || time_up || volt_hit || slope_hit)
            state_d = topoff_en ? nbcs_pkg::ST_TOPOFF
                                : nbcs_pkg::ST_TRICKLE;
        nbcs_pkg::ST_TOPOFF:
          if (CELL_OVER_MAX_IN)
            state_d = nbcs_pkg::ST_MCV_CHECK;
          else if (max_temp || time_up)
            state_d = nbcs_pkg::ST_TRICKLE;
        nbcs_pkg::ST_TRICKLE:
          if (CELL_OVER_MAX_IN)
            state_d = nbcs_pkg::ST_MCV_CHECK;
        nbcs_pkg::ST_MCV_CHECK:
          if (!CELL_OVER_MAX_IN)
            state_d = nbcs_pkg::ST_TRICKLE;
          else if (state_ms_q >= nbcs_pkg::OVERVOLT_CONFIRM_MS)
            state_d = nbcs_pkg::ST_ABSENT;
        nbcs_pkg::ST_ABSENT, nbcs_pkg::ST_HOLD:
          state_d = state_q;
        default:
          state_d = nbcs_pkg::ST_QUALIFY;
      endcase
  end
  assign entry = (state_d != state_q);

  always_ff @(posedge SYS_CLK_IN)
  begin
    if (RST_IN)
    begin
      state_q       <= nbcs_pkg::ST_HOLD;
      prev_supply_q <= 1'b0;
      prev_hold_n_q <= 1'b0;
      prev_dreq_n_q <= 1'b1;
      prev_over_q   <= 1'b0;
    end
    else
    begin
      state_q       <= state_d;
      prev_supply_q <= SUPPLY_OK_IN;
      prev_hold_n_q <= CHARGE_HOLD_N_IN;
      prev_dreq_n_q <= DISCHARGE_REQUEST_N_IN;
      prev_over_q   <= CELL_OVER_MAX_IN;
    end
  end

  // Millisecond timebase, state timer and sample interval.
  always_ff @(posedge SYS_CLK_IN)
  begin
    if (RST_IN)
    begin
      ms_div_q   <= 32'h0;
      state_ms_q <= 32'h0;
      samp_ms_q  <= 32'h0;
      holdoff_q  <= 1'b1;
    end
    else
    begin
      ms_div_q <= ms_tick ? 32'h0 : ms_div_q + 32'h1;
      if (entry)
        state_ms_q <= 32'h0;
      else if (ms_tick)
        state_ms_q <= state_ms_q + 32'h1;
      holdoff_q <= entry ? 1'b1 : (state_ms_q < holdoff_ms);
      if (ms_tick)
        samp_ms_q <= (samp_ms_q == SAMPLE_MS_P - 1) ? 32'h0
                                                    : samp_ms_q + 32'h1;
    end
  end

  // Burst of spaced measurements summed into one averaged sample.
  always_ff @(posedge SYS_CLK_IN)
  begin
    if (RST_IN)
    begin
      burst_q    <= 1'b0;
      done_q     <= 1'b0;
      meas_div_q <= 32'h0;
      meas_idx_q <= 6'h0;
      vsum_q     <= 17'h0;
      tsum_q     <= 16'h0;
    end
    else
    begin
      done_q <= 1'b0;
      if (!burst_q)
      begin
        if (ms_tick && samp_ms_q == SAMPLE_MS_P - 1)
        begin
          burst_q    <= 1'b1;
          meas_div_q <= 32'h0;
          meas_idx_q <= 6'h0;
          vsum_q     <= 17'h0;
          tsum_q     <= 16'h0;
        end
      end
      else if (meas_tick)
      begin
        meas_div_q <= 32'h0;
        meas_idx_q <= meas_idx_q + 6'h1;
        vsum_q     <= vsum_q + 17'(BATTERY_PAIR_VOLTAGE_CODE_IN);
        if (meas_idx_q < 6'(nbcs_pkg::MEAS_N_TEMP))
          tsum_q <= tsum_q + 16'(THERMAL_VOLTAGE_CODE_IN);
        if (meas_idx_q == 6'(peak_mode ? nbcs_pkg::MEAS_N_PEAK - 1
                                        : nbcs_pkg::MEAS_N_DROP - 1))
        begin
          burst_q <= 1'b0;
          done_q  <= 1'b1;
        end
      end
      else
        meas_div_q <= meas_div_q + 32'h1;
    end
  end

  // Sample history for the peak and slope tests, cleared at fast start.
  always_ff @(posedge SYS_CLK_IN)
  begin
    if (RST_IN || (entry && state_d == nbcs_pkg::ST_FAST))
    begin
      vmax_q    <= 12'h0;
      vmax_ok_q <= 1'b0;
      t1_q      <= 12'h0;
      t2_q      <= 12'h0;
      tcount_q  <= 2'h0;
    end
    else if (done_q && state_q == nbcs_pkg::ST_FAST)
    begin
      if (v_win && (!vmax_ok_q || vs_now > vmax_q))
      begin
        vmax_q    <= vs_now;
        vmax_ok_q <= 1'b1;
      end
      t2_q <= t1_q;
      t1_q <= ts_now;
      if (tcount_q != 2'h2)
        tcount_q <= tcount_q + 2'h1;
    end
  end

  always_ff @(posedge SYS_CLK_IN)
  begin
    if (RST_IN)
    begin
      vsamp_q <= 12'h0;
      tsamp_q <= 12'h0;
      cause_q <= 3'h0;
    end
    else
    begin
      if (done_q)
      begin
        vsamp_q <= vs_now;
        tsamp_q <= ts_now;
      end
      if (state_q == nbcs_pkg::ST_FAST && entry)
        cause_q <= {volt_hit, slope_hit, max_temp || time_up};
    end
  end

  // Charge gate pattern per state.
  always_comb
  begin
    case (state_d)
      nbcs_pkg::ST_FAST:
        gate_d = 1'b1;
      nbcs_pkg::ST_TOPOFF:
        gate_d = (pulse_q < GATE_ON_CYCLES_P);
      nbcs_pkg::ST_PENDING, nbcs_pkg::ST_TRICKLE:
        gate_d = (trk_period != 32'h0) &&
                 (pulse_q < GATE_ON_CYCLES_P);
      default:
        gate_d = 1'b0;
    endcase
  end

  always_ff @(posedge SYS_CLK_IN)
  begin
    if (RST_IN || entry)
      pulse_q <= 32'h0;
    else if ((state_q == nbcs_pkg::ST_TOPOFF &&
              pulse_q >= GATE_ON_CYCLES_P + TOPOFF_OFF_P - 1) ||
             (state_q != nbcs_pkg::ST_TOPOFF &&
              pulse_q >= trk_period - 32'h1))
      pulse_q <= 32'h0;
    else
      pulse_q <= pulse_q + 32'h1;
  end

  always_ff @(posedge SYS_CLK_IN)
  begin
    if (RST_IN)
    begin
      gate_q    <= 1'b0;
      gate_oe_q <= 1'b0;
      dis_q     <= 1'b0;
      dis_oe_q  <= 1'b0;
      blank_q   <= 1'b0;
    end
    else
    begin
      gate_q    <= gate_d && CHARGE_HOLD_N_IN;
      gate_oe_q <= CHARGE_HOLD_N_IN;
      dis_q     <= (state_d == nbcs_pkg::ST_DISCHARGE);
      dis_oe_q  <= CHARGE_HOLD_N_IN;
      blank_q   <= CELL_OVER_MAX_IN && CHARGE_HOLD_N_IN;
    end
  end

  // Zero wait AHB-Lite slave: config write in data phase, read data early.
  always_ff @(posedge SYS_CLK_IN)
  begin
    if (RST_IN)
    begin
      hwr_q    <= 1'b0;
      haddr_q  <= 8'h0;
      hrdata_q <= 32'h0;
      cfg_q    <= nbcs_pkg::CFG_RESET;
    end
    else
    begin
      hwr_q <= HSEL_IN && HTRANS_IN[1] && HREADY_IN && HWRITE_IN;
      if (HSEL_IN && HTRANS_IN[1] && HREADY_IN)
        haddr_q <= HADDR_IN[7:0];
      if (hwr_q && haddr_q == nbcs_pkg::REG_CONFIG)
        cfg_q <= HWDATA_IN[5:0];
      if (HSEL_IN && HTRANS_IN[1] && HREADY_IN && !HWRITE_IN)
      begin
        if (HADDR_IN[31:8] != 24'h0)
          hrdata_q <= 32'h0;
        else if (HADDR_IN[7:0] == nbcs_pkg::REG_CONFIG)
          hrdata_q <= {26'h0, cfg_q};
        else if (HADDR_IN[7:0] == nbcs_pkg::REG_STATUS)
          hrdata_q <= {21'h0, cause_q, holdoff_q, blank_q, dis_q, gate_q,
                       state_q};
        else if (HADDR_IN[7:0] == nbcs_pkg::REG_SAMPLE)
          hrdata_q <= {4'h0, tsamp_q, 4'h0, vsamp_q};
        else
          hrdata_q <= 32'h0;
      end
    end
  end

  assign HRDATA_OUT             = hrdata_q;
  assign HREADYOUT_OUT          = !RST_IN || 1'b1;
  assign HRESP_OUT              = 1'b0;
  assign CHARGE_GATE_OUT        = gate_q;
  assign CHARGE_GATE_OE_OUT     = gate_oe_q;
  assign DISCHARGE_DRIVE_OUT    = dis_q;
  assign DISCHARGE_DRIVE_OE_OUT = dis_oe_q;
  assign LAMP_BLANK_OUT         = blank_q;

  default clocking cb @(posedge SYS_CLK_IN);
  endclocking
  default disable iff (RST_IN);

  dis_end_a: assert property (
    state_q == nbcs_pkg::ST_DISCHARGE && CELL_UNDER_EDV_IN &&
    CHARGE_HOLD_N_IN && !dreq_fall && !new_cycle
    |=> !DISCHARGE_DRIVE_OUT && state_q == nbcs_pkg::ST_QUALIFY)
    else $error("discharge did not end at end level");
  dreq_start_a: assert property (
    CHARGE_HOLD_N_IN && dreq_fall |=> DISCHARGE_DRIVE_OUT ##1
    (DISCHARGE_DRIVE_OUT || $past(CELL_UNDER_EDV_IN) || !CHARGE_HOLD_N_IN ||
     $past(new_cycle) && $past(DISCHARGE_REQUEST_N_IN)))
    else $error("discharge request did not start discharge");
  cycle_first_a: assert property (
    CHARGE_HOLD_N_IN && !dreq_fall && new_cycle |=>
    state_q == ($past(DISCHARGE_REQUEST_N_IN) ? nbcs_pkg::ST_QUALIFY
                                              : nbcs_pkg::ST_DISCHARGE))
    else $error("new cycle began in the wrong step");
  hold_start_a: assert property (
    $rose(CHARGE_HOLD_N_IN) && DISCHARGE_REQUEST_N_IN && !dreq_fall
    |=> state_q == nbcs_pkg::ST_QUALIFY)
    else $error("hold release did not start a cycle");
  qual_fast_a: assert property (
    state_q == nbcs_pkg::ST_QUALIFY && CHARGE_HOLD_N_IN && !new_cycle &&
    !dreq_fall && !CELL_OVER_MAX_IN && !CELL_UNDER_EDV_IN && !temp_bad
    |=> state_q == nbcs_pkg::ST_FAST && CHARGE_GATE_OUT)
    else $error("qualified battery did not start fast charge");
  absent_stays_a: assert property (
    state_q == nbcs_pkg::ST_ABSENT && CHARGE_HOLD_N_IN && !new_cycle &&
    !dreq_fall |=> state_q == nbcs_pkg::ST_ABSENT && !CHARGE_GATE_OUT)
    else $error("battery absent state left without a new cycle");
  overvolt_stop_a: assert property (
    state_q == nbcs_pkg::ST_FAST && CELL_OVER_MAX_IN && CHARGE_HOLD_N_IN &&
    !new_cycle && !dreq_fall |=> !CHARGE_GATE_OUT && LAMP_BLANK_OUT)
    else $error("charge not stopped on over voltage");
  hold_release_a: assert property (
    !CHARGE_HOLD_N_IN |=> !CHARGE_GATE_OE_OUT && !DISCHARGE_DRIVE_OE_OUT &&
    !CHARGE_GATE_OUT && state_q == nbcs_pkg::ST_HOLD)
    else $error("outputs still driven while held");
  trickle_off_a: assert property (
    state_q == nbcs_pkg::ST_TRICKLE && cfg_idx == 4'h0 &&
    $stable(state_q) |-> !CHARGE_GATE_OUT)
    else $error("trickle pulses with trickle disabled");
endmodule // nbcs_sequencer
`default_nettype wire

// *** shared/nbcs_pkg.sv ***
`default_nettype none
package nbcs_pkg;
  localparam int unsigned CLK_HZ           = 100_000_000;
  localparam int unsigned US_PER_S         = 1_000_000;
  localparam int unsigned MS_PER_S         = 1_000;
  localparam int unsigned S_PER_MIN        = 60;
  localparam int unsigned CODE_W           = 12;
  localparam int unsigned LSB_UV           = 1_000;
  localparam int unsigned UV_PER_MV        = 1_000;
  localparam int unsigned MEAS_SPACING_US  = 57;
  localparam int unsigned SAMPLE_INTERVAL_S = 34;
  localparam int unsigned OVERVOLT_CONFIRM_MS = 1_500;
  localparam int unsigned GATE_ON_US       = 260;
  localparam int unsigned TOPOFF_OFF_US    = 1_820;
  localparam int unsigned DROP_VD_MV       = 12;
  localparam int unsigned DROP_PK_MV       = 6;
  localparam int unsigned TEMP_FALL_MV     = 16;
  localparam int unsigned MEAS_N_PEAK      = 32;
  localparam int unsigned MEAS_N_DROP      = 16;
  localparam int unsigned MEAS_N_TEMP      = 16;
  localparam int unsigned CFG_COMBOS       = 9;
  localparam int unsigned MS_CYCLES        = CLK_HZ / MS_PER_S;
  localparam int unsigned MEAS_CYCLES      =
    MEAS_SPACING_US * (CLK_HZ / US_PER_S);
  localparam int unsigned GATE_ON_CYCLES   = GATE_ON_US * (CLK_HZ / US_PER_S);
  localparam int unsigned TOPOFF_OFF_CYCLES =
    TOPOFF_OFF_US * (CLK_HZ / US_PER_S);
  localparam int unsigned SAMPLE_MS        = SAMPLE_INTERVAL_S * MS_PER_S;
  localparam int unsigned MS_PER_MIN       = S_PER_MIN * MS_PER_S;
  localparam logic [12:0] DROP_VD_CODES    =
    13'(DROP_VD_MV * UV_PER_MV / LSB_UV);
  localparam logic [12:0] DROP_PK_CODES    =
    13'(DROP_PK_MV * UV_PER_MV / LSB_UV);
  localparam logic [12:0] TEMP_FALL_CODES  =
    13'(TEMP_FALL_MV * UV_PER_MV / LSB_UV);
  localparam int unsigned SAFETY_MIN [CFG_COMBOS] =
    '{360, 180, 90, 45, 23, 180, 90, 45, 23};
  localparam int unsigned HOLDOFF_S [CFG_COMBOS] =
    '{137, 820, 410, 200, 100, 820, 410, 200, 100};
  localparam logic [8:0]  TOPOFF_EN_MAP    = 9'h1e0;
  localparam int unsigned TRICKLE_HZ [CFG_COMBOS] =
    '{0, 240, 120, 60, 30, 120, 60, 30, 15};
  localparam logic [1:0]  LEVEL_LOW        = 2'h0;
  localparam logic [1:0]  LEVEL_FLOAT      = 2'h1;
  localparam logic [1:0]  LEVEL_HIGH       = 2'h2;
  localparam logic [7:0]  REG_CONFIG       = 8'h00;
  localparam logic [7:0]  REG_STATUS       = 8'h04;
  localparam logic [7:0]  REG_SAMPLE       = 8'h08;
  localparam int unsigned CFG_VOLTAGE_TERM_SELECT_LSB     = 0;
  localparam int unsigned CFG_TMA_LSB      = 2;
  localparam int unsigned CFG_TMB_LSB      = 4;
  localparam logic [5:0]  CFG_RESET        = 6'h00;
  localparam int unsigned SAMPLE_T_LSB     = 16;
  typedef enum logic [3:0] {
    ST_HOLD, ST_DISCHARGE, ST_QUALIFY, ST_PENDING, ST_FAST,
    ST_TOPOFF, ST_TRICKLE, ST_MCV_CHECK, ST_ABSENT
  } nbcs_state_t;
endpackage
`default_nettype wire

// *** testbench/nbcs_switch_model.sv ***
`timescale 1ns/1ns
`default_nettype none
module nbcs_switch_model (
  input  wire logic clk_in,
  input  wire logic gate_in,
  input  wire logic gate_oe_in,
  input  wire logic dis_in,
  input  wire logic dis_oe_in,
  output logic      under_edv_out
);
  int level = 40;
  // The discharge switch drains the pack and the charge switch refills it.
  always @(posedge clk_in)
  begin
    if (dis_in && dis_oe_in && level > 0)
      level <= level - 1;
    else if (gate_in && gate_oe_in && level < 40)
      level <= level + 1;
  end
  assign under_edv_out = (level < 8);
endmodule // nbcs_switch_model
`default_nettype wire

// *** testbench/nickel_battery_charge_sequencer_tb.sv ***
`timescale 1ns/1ns
`default_nettype none
module nickel_battery_charge_sequencer_tb;
  logic        clk = 0, rst = 1, hsel = 0, hwrite = 0, dreq_n = 1;
  logic        hold_n = 1, ovr = 0, sok = 1;
  logic [3:0]  tf = 4'h0;
  logic [1:0]  htrans = 2'h0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, rd;
  logic [11:0] battery_pair_voltage = 12'h7d0, thermal_voltage = 12'h3e8;
  wire logic [31:0] hrdata;
  wire logic   hready, hresp, gate, gate_oe, dis, dis_oe, blank, edv;
  int          miscompares = 0, total_checks = 0, seed = 9, exp_st, np;
  always #5 clk = ~clk;
  always @(posedge clk)
  begin
    battery_pair_voltage <= 12'($random(seed));
    thermal_voltage <= 12'($random(seed));
  end
  nbcs_sequencer #(.MS_CYCLES_P(10), .MEAS_CYCLES_P(4),
    .GATE_ON_CYCLES_P(3), .TOPOFF_OFF_P(20), .TRICKLE_SCALE_P(2400),
    .SAMPLE_MS_P(5), .MS_PER_MIN_P(2)) DUT (
    .SYS_CLK_IN(clk), .RST_IN(rst), .HSEL_IN(hsel), .HADDR_IN(haddr),
    .HTRANS_IN(htrans), .HWRITE_IN(hwrite), .HSIZE_IN(3'h2),
    .HWDATA_IN(hwdata), .HREADY_IN(hready), .HRDATA_OUT(hrdata),
    .HREADYOUT_OUT(hready), .HRESP_OUT(hresp), .SUPPLY_OK_IN(sok),
    .DISCHARGE_REQUEST_N_IN(dreq_n), .CHARGE_HOLD_N_IN(hold_n),
    .CELL_OVER_MAX_IN(ovr), .CELL_UNDER_EDV_IN(edv),
    .TEMP_UNDER_TCO_IN(tf[0]), .TEMP_OVER_LTF_IN(tf[1]),
    .TEMP_UNDER_HTF_IN(tf[2]), .TEMP_OVER_TCO_WIN_IN(tf[3]),
    .BATTERY_PAIR_VOLTAGE_CODE_IN(battery_pair_voltage), .THERMAL_VOLTAGE_CODE_IN(thermal_voltage),
    .CHARGE_GATE_OUT(gate), .CHARGE_GATE_OE_OUT(gate_oe),
    .DISCHARGE_DRIVE_OUT(dis), .DISCHARGE_DRIVE_OE_OUT(dis_oe),
    .LAMP_BLANK_OUT(blank));
  nbcs_switch_model PM (.clk_in(clk), .gate_in(gate), .gate_oe_in(gate_oe),
    .dis_in(dis), .dis_oe_in(dis_oe), .under_edv_out(edv));
  task automatic chk(input string n, input logic [31:0] s,
                     input logic [31:0] e);
    total_checks++;
    if (s !== e)
    begin
      $display("FAIL %s expected %h seen %h", n, e, s);
      miscompares++;
    end
  endtask
  task automatic bus(input logic w, input logic [31:0] a,
                     input logic [31:0] d);
    hsel <= 1'b1; htrans <= 2'h2; haddr <= a; hwrite <= w;
    @(posedge clk);
    while (hready !== 1'b1) @(posedge clk);
    hsel <= 1'b0; htrans <= 2'h0; hwdata <= d;
    @(posedge clk);
    while (hready !== 1'b1) @(posedge clk);
    rd = hrdata;
  endtask
  task automatic pulses(input int n, output int c);
    c = 0;
    repeat (n)
    begin
      @(posedge clk);
      if (gate === 1'b1)
        c++;
    end
  endtask
  task automatic st();
    bus(1'b0, 32'h4, 32'h0);
    chk("state", {28'h0, rd[3:0]}, 32'(exp_st));
  endtask
  task automatic wrap_up();
    if (miscompares == 0 && total_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  initial
  begin
    repeat (20000) @(posedge clk);
    miscompares++;
    wrap_up();
  end
  initial
  begin
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    repeat (6) @(posedge clk);
    bus(1'b0, 32'h0, 32'h0);
    chk("config", rd, 32'h0);
    chk("hresp", {31'h0, hresp}, 32'h0);
    bus(1'b0, 32'hc, 32'h0);
    chk("unmapped", rd, 32'h0);
    exp_st = 4;
    st();
    chk("gate", {31'h0, gate}, 32'h1);
    bus(1'b1, 32'h0, 32'h15);
    bus(1'b0, 32'h0, 32'h0);
    chk("config", rd, 32'h15);
    bus(1'b1, 32'h0, 32'h0);
    ovr <= 1'b1;
    repeat (3) @(posedge clk);
    chk("blank", {31'h0, blank}, 32'h1);
    chk("gate", {31'h0, gate}, 32'h0);
    exp_st = 7;
    st();
    ovr <= 1'b0;
    repeat (3) @(posedge clk);
    exp_st = 6;
    st();
    dreq_n <= 1'b0;
    @(posedge clk);
    dreq_n <= 1'b1;
    repeat (3) @(posedge clk);
    chk("discharge", {31'h0, dis}, 32'h1);
    repeat (60) @(posedge clk);
    chk("discharge", {31'h0, dis}, 32'h0);
    exp_st = 3;
    st();
    hold_n <= 1'b0;
    repeat (3) @(posedge clk);
    chk("gate oe", {31'h0, gate_oe}, 32'h0);
    chk("dis oe", {31'h0, dis_oe}, 32'h0);
    ovr <= 1'b1;
    hold_n <= 1'b1;
    repeat (4) @(posedge clk);
    exp_st = 8;
    st();
    bus(1'b1, 32'h0, 32'h6);
    tf <= 4'ha;
    ovr <= 1'b0;
    repeat (10) @(posedge clk);
    exp_st = 4;
    st();
    tf <= 4'h1;
    repeat (3) @(posedge clk);
    exp_st = 6;
    st();
    pulses(20, np);
    chk("trickle pulses", np, 32'h6);
    bus(1'b1, 32'h0, 32'h1a);
    tf <= 4'h4;
    sok <= 1'b0;
    @(posedge clk);
    sok <= 1'b1;
    repeat (3) @(posedge clk);
    exp_st = 3;
    st();
    tf <= 4'h0;
    repeat (3) @(posedge clk);
    tf <= 4'h1;
    @(posedge clk);
    tf <= 4'h0;
    repeat (2) @(posedge clk);
    exp_st = 5;
    st();
    pulses(23, np);
    chk("topoff pulses", np, 32'h3);
    wrap_up();
  end
endmodule // nickel_battery_charge_sequencer_tb
`default_nettype wire
